/* rtl/sfwp_buffer.sv */
// two-entry valid/ready buffer for committed array words
`default_nettype none
module sfwp_buffer
    import sfwp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire sfwp_pkg::sfwp_word_type inWord,
    input wire logic inValid,
    output logic inReady,
    output logic [BUF_DEPTH-1:0] slotsUsed,
    output sfwp_pkg::sfwp_word_type outWord,
    output logic outValid,
    input wire logic outReady
);
    sfwp_word_type mem [BUF_DEPTH];
    logic rdPtr;
    logic wrPtr;
    logic [1:0] count;
    logic next_rdPtr;
    logic next_wrPtr;
    logic [1:0] next_count;
    logic doWrite;
    logic doRead;
    // pointer and count arithmetic
    always_comb begin
        doWrite = inValid && (count != 2'h2);
        doRead = (count != 2'h0) && outReady;
        next_wrPtr = wrPtr ^ doWrite;
        next_rdPtr = rdPtr ^ doRead;
        next_count = count + {1'b0, doWrite} - {1'b0, doRead};
    end
    // storage and pointers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdPtr <= 1'b0;
            wrPtr <= 1'b0;
            count <= 2'h0;
            mem[0] <= '0;
            mem[1] <= '0;
        end else begin
            rdPtr <= next_rdPtr;
            wrPtr <= next_wrPtr;
            count <= next_count;
            if (doWrite) begin
                mem[wrPtr] <= inWord;
            end
        end
    end
    assign inReady = (count != 2'h2);
    assign outValid = (count != 2'h0);
    assign outWord = mem[rdPtr];
    assign slotsUsed = count;
endmodule
`default_nettype wire

/* rtl/sfwp_core.sv */
// serial memory slave: write latch, status register, block protect, burst write
// Operation
// - write latch comes up cleared after reset.
// - set-latch opcode sets the write latch.
// - latch flag is set only by set-latch; status writes cannot touch it.
// - latch clears at chip-select rise ending clear, status, array, special, serial writes.
// - clear-latch opcode clears the latch; flag then reads zero.
// - status bits 0,4,5 read zero, bit 6 reads one; writes ignored.
// - bit 0 reads zero since writes never stall.
// - block-protect bits persist; reset does not clear them.
// - protect code selects none, upper quarter, upper half or whole array.
// - pin enable set and protect pin low blocks status writes.
// - protect pin never gates array writes.
// - array writes need latch set and address outside protected range.
// - read-status shifts the status byte out, msb first.
// - write-status loads pin enable and protect bits when allowed.
// - array write is opcode, three address bytes (low 18 bits), then data.
// - burst address increments per byte, wrapping from top to zero.
// - data taken msb first; write ends at chip-select rise.
// - on a protected address, stop incrementing and drop further bytes.
// - each byte commits after its eighth bit; bursts of any length.
// - every command starts at chip-select fall; one opcode per frame.
// - unknown opcode ignores input until next frame, data out stays off.
// - mode 0 if clock low at select fall, mode 3 if high.
// - sample on rising clock edges, change output on falling edges.
`default_nettype none
module sfwp_core
    import sfwp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic chipSelectN,
    input wire logic serialClock,
    input wire logic dataIn,
    input wire logic protectPinN,
    output logic dataOut,
    output logic dataOutEnable,
    output logic spiMode3,
    output logic writeLatchFlag,
    output sfwp_pkg::sfwp_word_type arrayWord,
    output logic arrayValid,
    input wire logic arrayReady,
    output logic [7:0] statusImage
);
    import sfwp_pkg::*;

    typedef enum {
        SFWP_IDLE, SFWP_OPCODE, SFWP_ADDR, SFWP_DATA, SFWP_STATUS_IN, SFWP_STATUS_OUT, SFWP_IGNORE
    } sfwp_state_type;

    // protection range check on an array address
    function automatic logic isProtected(input logic [1:0] bp, input logic [17:0] a);
        logic hit;
        hit = 1'b1;
        case (bp)
            BP_NONE: hit = 1'b0;
            BP_QUARTER: hit = (a >= PROT_QUARTER_BASE);
            BP_HALF: hit = (a >= PROT_HALF_BASE);
            default: hit = 1'b1;
        endcase
        return hit;
    endfunction

    // latch clears at the end of a frame carrying one of these opcodes
    function automatic logic isWriteOp(input logic [7:0] op);
        return (op == OP_CLEAR_WRITE_LATCH) || (op == OP_WRITE_STATUS) ||
            (op == OP_WRITE_ARRAY) || (op == OP_SPECIAL_SECTOR_WRITE) ||
            (op == OP_SERIAL_NUMBER_WRITE);
    endfunction

    logic [3:0] pinsSync;
    logic csN;
    logic sck;
    logic sdi;
    logic wpN;

    // all serial pins pass two flops before use; active-low pins go through
    // inverted so a cleared synchroniser reads as idle, not as a select fall
    sfwp_sync #(.W(4)) pinSync (
        .clk(clk),
        .rst(rst),
        .async({~chipSelectN, serialClock, dataIn, ~protectPinN}),
        .synced(pinsSync)
    );
    assign csN = ~pinsSync[3];
    assign sck = pinsSync[2];
    assign sdi = pinsSync[1];
    assign wpN = ~pinsSync[0];

    sfwp_state_type state;
    sfwp_state_type next_state;
    logic csPrev;
    logic sckPrev;
    logic [7:0] shiftIn;
    logic [7:0] next_shiftIn;
    logic [2:0] bitCount;
    logic [2:0] next_bitCount;
    logic [1:0] byteCount;
    logic [1:0] next_byteCount;
    logic [7:0] opcode;
    logic [7:0] next_opcode;
    logic [17:0] addr;
    logic [17:0] next_addr;
    logic stopped;
    logic next_stopped;
    logic [7:0] shiftOut;
    logic [7:0] next_shiftOut;
    logic latch;
    logic next_latch;
    sfwp_nv_type nv = '0;
    sfwp_nv_type next_nv;
    logic next_dataOut;
    logic next_dataOutEnable;
    logic next_spiMode3;
    sfwp_word_type pushWord;
    sfwp_word_type next_pushWord;
    logic pushValid;
    logic next_pushValid;
    logic bufReady;
    sfwp_word_type bufWord;
    logic bufValid;
    logic [7:0] next_statusImage;
    sfwp_word_type next_arrayWord;
    logic next_arrayValid;
    logic csFall;
    logic csRise;
    logic sckRise;
    logic sckFall;
    logic [7:0] inByte;
    logic [7:0] status;

    assign csFall = csPrev && !csN;
    assign csRise = !csPrev && csN;
    assign sckRise = !sckPrev && sck && !csN;
    assign sckFall = sckPrev && !sck && !csN;
    assign inByte = {shiftIn[6:0], sdi};

    // status byte image with fixed bits
    always_comb begin
        status = STATUS_FIXED;
        status[ST_LATCH] = latch;
        status[ST_BP_LOW] = nv.blockProtect[0];
        status[ST_BP_HIGH] = nv.blockProtect[1];
        status[ST_PIN_ENABLE] = nv.pinEnable;
    end

    // frame decoder, shifter, latch and protection state
    always_comb begin
        next_state = state;
        next_shiftIn = shiftIn;
        next_bitCount = bitCount;
        next_byteCount = byteCount;
        next_opcode = opcode;
        next_addr = addr;
        next_stopped = stopped;
        next_shiftOut = shiftOut;
        next_latch = latch;
        next_nv = nv;
        next_dataOut = dataOut;
        next_dataOutEnable = dataOutEnable;
        next_spiMode3 = spiMode3;
        next_pushWord = pushWord;
        next_pushValid = pushValid && !bufReady;
        if (csRise) begin
            // partial byte is dropped by returning to idle
            // opcode stays zero until all eight opcode bits are in
            if (isWriteOp(opcode)) begin
                next_latch = 1'b0;
            end
            next_state = SFWP_IDLE;
            next_dataOutEnable = 1'b0;
        end else if (csFall) begin
            next_state = SFWP_OPCODE;
            next_spiMode3 = sck;
            next_bitCount = 3'h0;
            next_opcode = 8'h00;
        end else if (sckRise && state != SFWP_IDLE && state != SFWP_IGNORE) begin
            next_shiftIn = inByte;
            next_bitCount = bitCount + 3'h1;
            if (bitCount == BIT_LAST) begin
                case (state)
                    SFWP_OPCODE: begin
                        next_opcode = inByte;
                        next_byteCount = 2'h0;
                        next_stopped = 1'b0;
                        case (inByte)
                            OP_SET_WRITE_LATCH: begin
                                next_latch = 1'b1;
                                next_state = SFWP_IGNORE;
                            end
                            OP_CLEAR_WRITE_LATCH: begin
                                // latch drops at the closing select rise
                                next_state = SFWP_IGNORE;
                            end
                            OP_READ_STATUS: begin
                                next_shiftOut = status;
                                next_state = SFWP_STATUS_OUT;
                            end
                            OP_WRITE_STATUS: next_state = SFWP_STATUS_IN;
                            OP_WRITE_ARRAY: next_state = SFWP_ADDR;
                            OP_SPECIAL_SECTOR_WRITE: next_state = SFWP_IGNORE;
                            OP_SERIAL_NUMBER_WRITE: next_state = SFWP_IGNORE;
                            default: next_state = SFWP_IGNORE;
                        endcase
                    end
                    SFWP_ADDR: begin
                        // upper six address bits fall off the 18-bit register
                        next_addr = {addr[ADDR_BITS-9:0], inByte};
                        next_byteCount = byteCount + 2'h1;
                        if (byteCount == BYTE_LAST_ADDR) begin
                            next_state = SFWP_DATA;
                        end
                    end
                    SFWP_STATUS_IN: begin
                        // protect pin only matters with pin enable set
                        if (latch && !(nv.pinEnable && !wpN)) begin
                            next_nv.pinEnable = inByte[ST_PIN_ENABLE];
                            next_nv.blockProtect = {inByte[ST_BP_HIGH], inByte[ST_BP_LOW]};
                        end
                        next_state = SFWP_IGNORE;
                    end
                    SFWP_DATA: begin
                        // pin not consulted for the array
                        if (!latch || stopped || isProtected(nv.blockProtect, addr)) begin
                            next_stopped = latch || stopped;
                        end else begin
                            next_pushWord = '{addr: addr, data: inByte};
                            next_pushValid = 1'b1;
                            next_addr = (addr == ADDR_LAST) ? ADDR_ZERO : addr + 18'h1;
                        end
                    end
                    default: next_state = state;
                endcase
            end
        end else if (sckFall && state == SFWP_STATUS_OUT) begin
            next_dataOutEnable = 1'b1;
            next_dataOut = shiftOut[7];
            next_shiftOut = {shiftOut[6:0], 1'b0};
        end
    end

    // registers; block protect and pin enable keep their value over reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= SFWP_IDLE;
            csPrev <= 1'b1;
            sckPrev <= 1'b0;
            shiftIn <= 8'h00;
            bitCount <= 3'h0;
            byteCount <= 2'h0;
            opcode <= 8'h00;
            addr <= ADDR_ZERO;
            stopped <= 1'b0;
            shiftOut <= 8'h00;
            latch <= 1'b0;
            dataOut <= 1'b0;
            dataOutEnable <= 1'b0;
            spiMode3 <= 1'b0;
            pushWord <= '0;
            pushValid <= 1'b0;
        end else begin
            state <= next_state;
            csPrev <= csN;
            sckPrev <= sck;
            shiftIn <= next_shiftIn;
            bitCount <= next_bitCount;
            byteCount <= next_byteCount;
            opcode <= next_opcode;
            addr <= next_addr;
            stopped <= next_stopped;
            shiftOut <= next_shiftOut;
            latch <= next_latch;
            dataOut <= next_dataOut;
            dataOutEnable <= next_dataOutEnable;
            spiMode3 <= next_spiMode3;
            pushWord <= next_pushWord;
            pushValid <= next_pushValid;
        end
    end

    // nonvolatile bits: no reset term, initial value is the shipped value
    always_ff @(posedge clk) begin
        nv <= next_nv;
    end

    // buffered commit path toward the array
    sfwp_buffer wordBuf (
        .clk(clk),
        .rst(rst),
        .inWord(pushWord),
        .inValid(pushValid),
        .inReady(bufReady),
        .slotsUsed(),
        .outWord(bufWord),
        .outValid(bufValid),
        .outReady(arrayReady && !(arrayValid && !arrayReady) && !arrayValid)
    );

    // output registers
    always_comb begin
        next_statusImage = status;
        next_arrayWord = arrayWord;
        next_arrayValid = arrayValid && !arrayReady;
        if (!next_arrayValid && bufValid && arrayReady && !arrayValid) begin
            next_arrayWord = bufWord;
            next_arrayValid = 1'b1;
        end
        next_statusImage[ST_FIXED_ONE] = 1'b1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            statusImage <= STATUS_FIXED;
            arrayWord <= '0;
            arrayValid <= 1'b0;
            writeLatchFlag <= 1'b0;
        end else begin
            statusImage <= next_statusImage;
            arrayWord <= next_arrayWord;
            arrayValid <= next_arrayValid;
            writeLatchFlag <= next_latch;
        end
    end
endmodule
`default_nettype wire

/* rtl/sfwp_pkg.sv */
// package: opcodes, status layout, protection ranges, shared types
`default_nettype none
package sfwp_pkg;
    localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
    localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_WRITE_ARRAY = 8'h02;
    localparam logic [7:0] OP_SPECIAL_SECTOR_WRITE = 8'h42;
    localparam logic [7:0] OP_SERIAL_NUMBER_WRITE = 8'hc2;
    localparam int ADDR_BITS = 18;
    localparam int ADDR_BYTES = 3;
    localparam logic [17:0] ADDR_LAST = 18'h3ffff;
    localparam logic [17:0] ADDR_ZERO = 18'h00000;
    localparam logic [17:0] PROT_QUARTER_BASE = 18'h30000;
    localparam logic [17:0] PROT_HALF_BASE = 18'h20000;
    localparam logic [1:0] BP_NONE = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF = 2'h2;
    // status bit positions
    localparam int ST_LATCH = 1;
    localparam int ST_BP_LOW = 2;
    localparam int ST_BP_HIGH = 3;
    localparam int ST_FIXED_ONE = 6;
    localparam int ST_PIN_ENABLE = 7;
    localparam logic [7:0] STATUS_FIXED = 8'h40;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [1:0] BYTE_LAST_ADDR = 2'h2;
    localparam int BUF_DEPTH = 2;
    typedef struct packed {
        logic [17:0] addr;
        logic [7:0] data;
    } sfwp_word_type;
    typedef struct packed {
        logic pinEnable;
        logic [1:0] blockProtect;
    } sfwp_nv_type;
endpackage
`default_nettype wire

/* rtl/sfwp_sync.sv */
// two-flop synchroniser for the serial pins
`default_nettype none
module sfwp_sync #(
    parameter int W = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] async,
    output logic [W-1:0] synced
);
    logic [W-1:0] stage1;
    logic [W-1:0] next_stage1;
    logic [W-1:0] next_synced;
    // pass-through next values
    always_comb begin
        next_stage1 = async;
        next_synced = stage1;
    end
    // two flops, first read only by the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1 <= '0;
            synced <= '0;
        end else begin
            stage1 <= next_stage1;
            synced <= next_synced;
        end
    end
endmodule
`default_nettype wire

/* tb/sfwp_core_sva.sv */
// checker: port properties of the serial memory slave
`default_nettype none
module sfwp_core_sva
    import sfwp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic chipSelectN,
    input wire logic serialClock,
    input wire logic protectPinN,
    input wire logic dataOutEnable,
    input wire logic spiMode3,
    input wire logic writeLatchFlag,
    input wire sfwp_pkg::sfwp_word_type arrayWord,
    input wire logic arrayValid,
    input wire logic arrayReady,
    input wire logic [7:0] statusImage
);
    timeunit 1ns;
    timeprecision 100ps;
    // true where the protect code covers the address
    function automatic logic inProt(input logic [1:0] bp, input logic [17:0] a);
        return bp == 2'h3 || (bp == BP_HALF && a >= PROT_HALF_BASE)
            || (bp == BP_QUARTER && a >= PROT_QUARTER_BASE);
    endfunction
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // latch and status layout
    reset_state_a: assert property (
        $fell(rst) |-> !writeLatchFlag && statusImage == STATUS_FIXED)
        else $error("latch or status wrong after reset");
    fixed_bits_a: assert property (
        statusImage[6] && statusImage[5:4] == 2'h0 && !statusImage[0])
        else $error("fixed status bits wrong");
    latch_shown_a: assert property (
        $rose(writeLatchFlag) |-> ##[0:3] statusImage[1])
        else $error("latch not shown in status");
    latch_drop_a: assert property (
        $fell(writeLatchFlag) |-> chipSelectN)
        else $error("latch cleared inside a frame");
    // status writes need the latch and an unlocked pin
    status_guard_a: assert property (
        $changed(statusImage[7:2]) && !$past(rst, 2) |-> $past(writeLatchFlag))
        else $error("status changed without latch");
    pin_lock_a: assert property (
        $changed(statusImage[7:2]) && !$past(rst, 2)
        |-> !$past(statusImage[7]) || $past(protectPinN))
        else $error("status changed while pin locked");
    out_enable_a: assert property (
        $rose(dataOutEnable) |-> !chipSelectN)
        else $error("data out driven outside a frame");
    // array words
    array_hold_a: assert property (
        arrayValid && !arrayReady |=> arrayValid && $stable(arrayWord))
        else $error("array word dropped while stalled");
    array_prot_a: assert property (
        arrayValid |-> !inProt(statusImage[3:2], arrayWord.addr))
        else $error("protected address written");
    mode_pick_a: assert property (
        $fell(chipSelectN) |-> ##6 spiMode3 == $past(serialClock, 6))
        else $error("bus mode not taken from clock level");
    cover property (arrayValid && arrayReady);
    cover property ($rose(dataOutEnable));
    cover property ($changed(statusImage[3:2]));
endmodule
bind sfwp_core sfwp_core_sva u_sfwp_core_sva (.clk, .rst, .chipSelectN, .serialClock,
    .protectPinN, .dataOutEnable, .spiMode3, .writeLatchFlag, .arrayWord, .arrayValid,
    .arrayReady, .statusImage);
`default_nettype wire

/* tb/sfwp_spi_master.sv */
// serial bus master model: framed transfers in mode 0 or 3, msb first
`default_nettype none
module sfwp_spi_master (
    input wire logic clk,
    output logic chipSelectN,
    output logic serialClock,
    output logic dataIn,
    input wire logic dataOut
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle levels
    initial begin
        chipSelectN = 1'b1;
        serialClock = 1'b0;
        dataIn = 1'b0;
    end
    // half a link period, four system clocks
    task automatic hp();
        repeat (4) @(posedge clk);
        #1;
    endtask
    // one frame of n bytes plus extra loose bits; rx keeps the last eight bits read
    task automatic frame(input logic m3, input int n, input logic [7:0] b [8],
            input int extra, output logic [7:0] rx);
        int i;
        rx = 8'h00;
        serialClock = m3;
        hp();
        chipSelectN = 1'b0; // one opcode per select
        hp();
        for (i = 0; i < n * 8 + extra; i++) begin
            serialClock = 1'b0;
            dataIn = (i < n * 8) ? b[i / 8][7 - i % 8] : ~dataIn; // msb first
            hp();
            serialClock = 1'b1;
            hp();
            rx = {rx[6:0], dataOut}; // read just before the next fall
        end
        serialClock = m3;
        hp();
        chipSelectN = 1'b1;
        dataIn = ~dataIn; // released line does not keep its value
        hp();
    endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
// testbench: latch, status register, block protect and burst write over the serial pins
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import sfwp_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic protectPinN = 1'b1;
    logic arrayReady = 1'b1;
    logic chipSelectN, serialClock, dataIn, dataOut, dataOutEnable, spiMode3, writeLatchFlag;
    logic arrayValid;
    logic [7:0] statusImage, rx;
    logic [7:0] b [8];
    logic [17:0] starts [4] = '{18'h3fffe, 18'h2fffe, 18'h1fffe, 18'h00000};
    sfwp_word_type arrayWord;
    sfwp_word_type expQ [$];
    int errCount = 0;
    int checked = 0;
    int seed = 51527;
    always #12.5 clk = ~clk;
    sfwp_core u_sfwp_core (.clk, .rst, .chipSelectN, .serialClock, .dataIn, .protectPinN,
        .dataOut, .dataOutEnable, .spiMode3, .writeLatchFlag, .arrayWord, .arrayValid,
        .arrayReady, .statusImage);
    sfwp_spi_master u_sfwp_spi_master (.clk, .chipSelectN, .serialClock, .dataIn, .dataOut);
    // compare, count, report
    task automatic check(input string name, input logic [25:0] seen, input logic [25:0] exp);
        checked++;
        if (seen !== exp) begin
            errCount++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic close_out();
        if (errCount == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    function automatic logic inProt(input logic [1:0] bp, input logic [17:0] a);
        return bp == 2'h3 || (bp == 2'h2 && a >= 18'h20000) || (bp == 2'h1 && a >= 18'h30000);
    endfunction
    // frame helpers, random bus mode per frame
    task automatic send(input int n, input int extra);
        logic m3;
        m3 = 1'($random(seed));
        u_sfwp_spi_master.frame(m3, n, b, extra, rx);
        check("spiMode3", {25'h0, spiMode3}, {25'h0, m3});
        check("dataOutEnable", {25'h0, dataOutEnable}, 26'h0);
    endtask
    task automatic cmd(input logic [7:0] op);
        b[0] = op;
        send(1, 0);
    endtask
    task automatic write_status(input logic [7:0] d);
        b[0] = OP_WRITE_STATUS;
        b[1] = d;
        send(2, 0);
    endtask
    task automatic read_status(input logic [7:0] exp);
        b[0] = OP_READ_STATUS;
        b[1] = 8'($random(seed));
        send(2, 0);
        check("status byte", {18'h00000, rx}, {18'h00000, exp});
        check("statusImage", {18'h00000, statusImage}, {18'h00000, exp});
        check("writeLatchFlag", {25'h0, writeLatchFlag}, {25'h0, exp[1]});
    endtask
    // array burst, noting the words that must reach the array
    task automatic burst(input logic [17:0] start, input int cnt, input logic [1:0] bp,
            input logic we, input int extra);
        int i;
        logic [17:0] a;
        logic stop;
        b[0] = OP_WRITE_ARRAY;
        b[1] = {6'h2a, start[17:16]}; // upper six bits ignored
        b[2] = start[15:8];
        b[3] = start[7:0];
        stop = 1'b0;
        for (i = 0; i < cnt; i++) begin
            a = start + 18'(i); // wraps at the top
            b[4 + i] = 8'($random(seed));
            stop = stop | inProt(bp, a);
            if (!stop && we) expQ.push_back({a, b[4 + i]});
        end
        send(4 + cnt, extra);
    endtask
    // sink stalls at random
    always @(posedge clk) #1 arrayReady = 1'($random(seed));
    // accepted words against the oldest note
    always @(posedge clk) begin
        if (arrayValid === 1'b1 && arrayReady) begin
            check("arrayWord", arrayWord, expQ.size() > 0 ? expQ.pop_front() : 26'hx);
        end
    end
    // watchdog
    initial begin
        repeat (60000) @(posedge clk);
        errCount++;
        close_out();
    end
    // main sequence
    initial begin
        int code;
        logic [7:0] ops [3] = '{OP_CLEAR_WRITE_LATCH, OP_SPECIAL_SECTOR_WRITE,
            OP_SERIAL_NUMBER_WRITE};
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        read_status(STATUS_FIXED);
        b[1] = 8'hff;
        b[0] = 8'h77;
        send(2, 0);
        read_status(STATUS_FIXED);
        burst(18'h00100, 2, BP_NONE, 1'b0, 0);
        for (code = 0; code < 3; code++) begin
            cmd(OP_SET_WRITE_LATCH);
            read_status(8'h42);
            cmd(ops[code]);
            read_status(8'h40);
        end
        cmd(OP_SET_WRITE_LATCH); // own frame before the status write
        write_status(8'hff);
        read_status(8'hcc);
        protectPinN = 1'b0;
        cmd(OP_SET_WRITE_LATCH);
        write_status(8'h00);
        read_status(8'hcc);
        protectPinN = 1'b1;
        cmd(OP_SET_WRITE_LATCH);
        write_status(8'h00);
        protectPinN = 1'b0;
        for (code = 0; code < 4; code++) begin
            cmd(OP_SET_WRITE_LATCH);
            write_status({4'h3, code[1:0], 2'h3});
            cmd(OP_SET_WRITE_LATCH);
            burst(starts[code], 4, code[1:0], 1'b1, 5);
            read_status({4'h4, code[1:0], 2'h0});
        end
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        read_status(8'h4c);
        check("words left", 26'(expQ.size()), 26'h0);
        close_out();
    end
endmodule
`default_nettype wire
